// *** inc/adcm_pkg.sv ***
// adcm_pkg: register map, field layouts and timing counts of the converter mode/timing control
package adcm_pkg;

  // ==========================================================
  // register map
  localparam logic [27:0] ADCM_ADDR_MODE0 = 28'hffff200;
  localparam logic [27:0] ADCM_ADDR_MODE1 = 28'hffff201;
  localparam logic [7:0] ADCM_MODE0_RST = 8'h00;
  localparam logic [7:0] ADCM_MODE1_RST = 8'h00;

  // ==========================================================
  // field layouts
  typedef struct packed {
    logic conv_enable;        // bit 7
    logic zero6;              // bit 6, reads zero
    logic [1:0] op_mode;      // op_mode_hi, op_mode_lo
    logic [1:0] trig_edge;    // trig_edge_hi, trig_edge_lo
    logic hw_trigger_select;  // bit 1
    logic conv_busy_flag;     // bit 0, read only
  } adcm_mode0_t;

  typedef struct packed {
    logic high_speed_select;  // bit 7
    logic [3:0] zero6_3;      // reads zero
    logic [2:0] conv_time_sel;
  } adcm_mode1_t;

  // op_mode[1] set means one-shot
  localparam int ADCM_OP_ONESHOT_BIT = 1;
  localparam logic [1:0] ADCM_EDGE_FALL = 2'h1;
  localparam logic [1:0] ADCM_EDGE_RISE = 2'h2;
  localparam logic [1:0] ADCM_EDGE_BOTH = 2'h3;

  // ==========================================================
  // timing counts in fxx cycles, indexed by conv_time_sel
  localparam logic [7:0] ADCM_STAB_CYC [0:7] = '{8'h0d, 8'h1a, 8'h27, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32};
  localparam logic [7:0] ADCM_CONV_CYC [0:7] = '{8'h1a, 8'h34, 8'h4e, 8'h68, 8'h82, 8'h9c, 8'hb6, 8'hd0};
  localparam logic [7:0] ADCM_RESP_BASE = 8'h04;
  localparam int ADCM_RESULT_LSB = 6;

  typedef enum logic [2:0] {
    ADCM_S_IDLE,
    ADCM_S_STAB,
    ADCM_S_TWAIT,
    ADCM_S_TRESP,
    ADCM_S_CONV,
    ADCM_S_WAITP,
    ADCM_S_DONE
  } adcm_state_t;

endpackage : adcm_pkg

// *** core/adcm_trig_sync.sv ***
// adcm_trig_sync: trigger pin synchroniser with filtered edge pulses
`timescale 1ns/1ps
module adcm_trig_sync (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // asynchronous pin
  input wire logic i_pin,
  // one-cycle edge pulses
  output logic o_rise,
  output logic o_fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lvl_r <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (s2_r == s3_r && s3_r != lvl_r) begin
        lvl_r <= s3_r;
        o_rise <= s3_r;
        o_fall <= ~s3_r;
      end
    end
  end

endmodule : adcm_trig_sync

// *** core/adcm_top.sv ***
// adcm_top: mode registers and conversion sequencing of the 10-bit converter
//
// Behaviour
// RULE1: enable bit 0 stops, 1 enables conversion
// RULE2: mode field selects continuous/one-shot, select/scan
// RULE3: edge field selects none, falling, rising, both
// RULE4: trigger bit selects software or hardware trigger
// RULE5: busy bit reads 1 while converting
// RULE6: writes to busy bit are discarded
// RULE7: reset clears first mode register
// RULE8: byte or single-bit reads and writes
// RULE9: software keeps time code while enabled
// RULE10: some modes: software writes only while stopped
// RULE11: software trigger: busy write restarts conversion
// RULE12: hardware trigger: busy write returns to waiting
// RULE13: software pairs hardware trigger with high speed
// RULE14: no trigger during first stabilization
// RULE15: normal short codes: stab, conv, wait counts
// RULE16: codes 011-111: stab 50, longer conversions
// RULE17: trigger response delay 4 plus code
// RULE18: software avoids codes barred for its clock
// RULE19: software avoids first register on slow clocks
// RULE20: software disables converter when unused
// RULE21: normal mode: end event after wait period
// RULE22: high speed: end event right after conversion
// RULE23: continuous high speed: stabilize only once
// RULE24: result in upper ten bits, low six zero
// RULE25: interval counters run on fxx, restart
// RULE26: speed bit selects mode, bits 6-3 zero
`timescale 1ns/1ps
module adcm_top
  import adcm_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // peripheral register port
  input wire logic [27:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic i_bit_access,
  input wire logic [2:0] i_bit_idx,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // writes to the channel, compare and trigger-source registers
  input wire logic i_other_ctl_wr,
  // trigger sources
  input wire logic i_ext_trigger_pin,
  input wire logic i_timer_trig,
  input wire logic i_timer_src_sel,
  // analog core
  input wire logic [9:0] i_sar_result,
  // status and result
  output logic o_conv_busy_flag,
  output logic o_conv_end_irq,
  output logic [15:0] o_result
);

  // ==========================================================
  // registers and access decode
  adcm_mode0_t m0_r;
  adcm_mode1_t m1_r;
  adcm_mode0_t m0_nxt;
  adcm_mode1_t m1_nxt;
  adcm_state_t st_r;
  adcm_state_t st_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] cyc_r;
  logic wr0;
  logic wr1;
  logic ld;
  logic cnt_done;
  logic restart;
  logic hw_trig;
  logic ext_rise;
  logic ext_fall;
  logic ext_ev;
  logic end_ev;
  logic busy_nxt;
  logic [2:0] code;

  assign wr0 = i_wr_en && i_addr == ADCM_ADDR_MODE0;
  assign wr1 = i_wr_en && i_addr == ADCM_ADDR_MODE1;
  assign code = m1_r.conv_time_sel;

  // merge a byte or single-bit write into the current value
  function automatic logic [7:0] merge(input logic [7:0] cur, input logic bitop, input logic [2:0] idx,
                                       input logic [7:0] wd);
    logic [7:0] v;
    v = cur;
    if (bitop) begin
      v[idx] = wd[0];
    end else begin
      v = wd;
    end
    return v;
  endfunction : merge

  always_comb begin
    m0_nxt = m0_r;
    m1_nxt = m1_r;
    if (wr0) begin
      m0_nxt = adcm_mode0_t'(merge(m0_r, i_bit_access, i_bit_idx, i_wdata)); // RULE8
      m0_nxt.zero6 = 1'b0;
      m0_nxt.conv_busy_flag = 1'b0; // RULE6
    end
    if (wr1) begin
      m1_nxt = adcm_mode1_t'(merge(m1_r, i_bit_access, i_bit_idx, i_wdata)); // RULE8
      m1_nxt.zero6_3 = 4'h0; // RULE26
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      m0_r <= adcm_mode0_t'(ADCM_MODE0_RST); // RULE7
      m1_r <= adcm_mode1_t'(ADCM_MODE1_RST);
    end else begin
      m0_r <= m0_nxt;
      m1_r <= m1_nxt;
    end
  end

  // busy bit is not stored in the register; it is the live sequencer status
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      logic [7:0] v;
      v = 8'h00;
      if (i_addr == ADCM_ADDR_MODE0) begin
        v = {m0_r[7:1], o_conv_busy_flag}; // RULE5
      end else if (i_addr == ADCM_ADDR_MODE1) begin
        v = m1_r;
      end
      o_rdata <= i_bit_access ? {7'h00, v[i_bit_idx]} : v; // RULE8
    end
  end

  // ==========================================================
  // trigger selection
  adcm_trig_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_ext_trigger_pin),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  always_comb begin
    unique case (m0_r.trig_edge)
      ADCM_EDGE_FALL: ext_ev = ext_fall; // RULE3
      ADCM_EDGE_RISE: ext_ev = ext_rise; // RULE3
      ADCM_EDGE_BOTH: ext_ev = ext_rise | ext_fall; // RULE3
      default: ext_ev = 1'b0;
    endcase
  end

  assign hw_trig = i_timer_src_sel ? i_timer_trig : ext_ev; // RULE4

  // ==========================================================
  // sequencer
  assign cnt_done = cnt_r == 8'h00;
  // restart only in high-speed continuous modes; other modes are written while stopped
  assign restart = (wr0 || i_other_ctl_wr) && o_conv_busy_flag && m1_r.high_speed_select
                   && !m0_r.op_mode[ADCM_OP_ONESHOT_BIT];

  function automatic adcm_state_t after_conv(input adcm_mode0_t m0, input logic hs);
    if (m0.hw_trigger_select) begin
      return ADCM_S_TWAIT;
    end else if (m0.op_mode[ADCM_OP_ONESHOT_BIT]) begin // RULE2
      return ADCM_S_DONE;
    end else if (hs) begin
      return ADCM_S_CONV; // RULE23
    end
    return ADCM_S_STAB;
  endfunction : after_conv

  always_comb begin
    st_nxt = st_r;
    end_ev = 1'b0;
    if (!m0_nxt.conv_enable) begin
      st_nxt = ADCM_S_IDLE; // RULE1
    end else if (!m0_r.conv_enable) begin
      st_nxt = ADCM_S_STAB; // RULE1
    end else if (restart) begin
      st_nxt = m0_r.hw_trigger_select ? ADCM_S_TWAIT : ADCM_S_STAB; // RULE11 RULE12
    end else begin
      unique case (st_r)
        ADCM_S_STAB: if (cnt_done) st_nxt = m0_r.hw_trigger_select ? ADCM_S_TWAIT : ADCM_S_CONV;
        ADCM_S_TWAIT: if (hw_trig) st_nxt = ADCM_S_TRESP; // RULE4
        ADCM_S_TRESP: if (cnt_done) st_nxt = ADCM_S_CONV;
        ADCM_S_CONV: begin
          if (cnt_done && m1_r.high_speed_select) begin
            st_nxt = after_conv(m0_r, 1'b1);
            end_ev = 1'b1; // RULE22
          end else if (cnt_done) begin
            st_nxt = ADCM_S_WAITP;
          end
        end
        ADCM_S_WAITP: begin
          if (cnt_done) begin
            st_nxt = after_conv(m0_r, 1'b0);
            end_ev = 1'b1; // RULE21
          end
        end
        ADCM_S_IDLE, ADCM_S_DONE: st_nxt = st_r;
      endcase
    end
  end

  // counter reloads on every state entry, restart or completed interval
  assign ld = st_nxt != st_r || restart || cnt_done;

  always_comb begin
    cnt_nxt = 8'h00;
    unique case (st_nxt)
      ADCM_S_STAB: cnt_nxt = ADCM_STAB_CYC[code] - 8'h01; // RULE15 RULE16
      ADCM_S_TRESP: cnt_nxt = ADCM_RESP_BASE + {5'h00, code} - 8'h01; // RULE17
      ADCM_S_CONV, ADCM_S_WAITP: cnt_nxt = ADCM_CONV_CYC[code] - 8'h01; // RULE15 RULE16
      ADCM_S_IDLE, ADCM_S_TWAIT, ADCM_S_DONE: cnt_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_r <= ADCM_S_IDLE;
      cnt_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= ld ? cnt_nxt : cnt_r - 8'h01; // RULE25
    end
  end

  assign busy_nxt = st_nxt inside {ADCM_S_STAB, ADCM_S_TRESP, ADCM_S_CONV, ADCM_S_WAITP};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_conv_busy_flag <= 1'b0;
      o_conv_end_irq <= 1'b0;
      o_result <= 16'h0000;
    end else begin
      o_conv_busy_flag <= busy_nxt; // RULE5
      o_conv_end_irq <= end_ev;
      if (st_r == ADCM_S_CONV && cnt_done && !restart) begin
        o_result <= {i_sar_result, 6'h00}; // RULE24
      end
    end
  end

  // ==========================================================
  // checks
  always_ff @(posedge i_core_clk) begin
    if (i_rst || ld) begin
      cyc_r <= 8'h00;
    end else begin
      cyc_r <= cyc_r + 8'h01;
    end
  end

  a_stop_when_off: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE1
    !m0_r.conv_enable |-> st_r == ADCM_S_IDLE && !o_conv_busy_flag)
    else $error("converter active while disabled");

  a_reset_clears: assert property (@(posedge i_core_clk) // RULE7
    i_rst |=> m0_r == ADCM_MODE0_RST && m1_r == ADCM_MODE1_RST)
    else $error("mode registers not cleared by reset");

  a_busy_readback: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE5
    i_rd_en && !i_bit_access && i_addr == ADCM_ADDR_MODE0 |=> o_rdata[0] == $past(o_conv_busy_flag))
    else $error("busy bit read back wrong");

  a_busy_write_ignored: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
    wr0 |=> !m0_r.conv_busy_flag && !m0_r.zero6)
    else $error("write reached busy bit");

  a_stab_length: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE15
    st_r == ADCM_S_STAB && cnt_done |-> cyc_r == ADCM_STAB_CYC[code] - 8'h01)
    else $error("stabilization length wrong");

  a_conv_length: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE16
    st_r == ADCM_S_CONV && cnt_done |-> cyc_r == ADCM_CONV_CYC[code] - 8'h01)
    else $error("conversion length wrong");

  a_resp_length: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE17
    st_r == ADCM_S_TRESP && cnt_done |-> cyc_r == ADCM_RESP_BASE + {5'h00, code} - 8'h01)
    else $error("trigger response length wrong");

  a_irq_after_wait: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE21
    o_conv_end_irq && !$past(m1_r.high_speed_select) |-> $past(st_r) == ADCM_S_WAITP)
    else $error("normal mode end event without wait");

  a_irq_high_speed: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE22
    st_r == ADCM_S_CONV && cnt_done && m1_r.high_speed_select && !restart && m0_nxt.conv_enable
    |=> o_conv_end_irq && st_r != ADCM_S_WAITP)
    else $error("high speed end event late");

  a_cont_no_stab: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE23
    st_r == ADCM_S_CONV && st_nxt != ADCM_S_CONV && m1_r.high_speed_select && !restart
    |-> st_nxt != ADCM_S_STAB)
    else $error("stabilization between high speed conversions");

  a_hw_abort: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE12
    restart && m0_r.hw_trigger_select && m0_nxt.conv_enable |=> st_r == ADCM_S_TWAIT && !o_conv_busy_flag)
    else $error("hardware mode abort did not return to waiting");

  a_result_low_zero: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE24
    o_conv_end_irq && !$past(m1_r.high_speed_select, 1) |-> o_result[5:0] == 6'h00)
    else $error("result low bits not zero");

endmodule : adcm_top

// *** bench/adcm_trig_model.sv ***
// adcm_trig_model: external trigger pin and timer compare event sources
`timescale 1ns/1ps
module adcm_trig_model (
  // clock
  input wire logic i_core_clk,
  // requests from the bench
  input wire logic i_pin_req,
  input wire logic i_timer_req,
  // trigger outputs
  output logic o_pin,
  output logic o_timer
);
  // ==========================================================
  // event generation
  logic pin_q;
  logic tmr_q;
  initial begin
    o_pin = 1'b0;
    o_timer = 1'b0;
    pin_q = 1'b0;
    tmr_q = 1'b0;
  end
  // fires only on command; the bench keeps requests out of the stabilization interval
  always @(posedge i_core_clk) begin
    pin_q <= i_pin_req;
    tmr_q <= i_timer_req;
  end
  // timer event lasts one cycle, the pin toggles once per request
  always @(negedge i_core_clk) begin
    o_timer <= tmr_q;
    if (pin_q) begin
      o_pin <= ~o_pin;
    end
  end
endmodule : adcm_trig_model

// *** bench/tb_top.sv ***
// tb_top: self-checking bench for the converter mode and timing control
`timescale 1ns/1ps
module tb_top
  import adcm_pkg::*;
;
  // ==========================================================
  // stimulus and wiring
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [27:0] i_addr = 28'h0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_bit_access = 1'b0;
  logic [2:0] i_bit_idx = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_other_ctl_wr = 1'b0;
  logic i_timer_src_sel = 1'b0;
  logic [9:0] i_sar_result = 10'h000;
  logic pin_req = 1'b0;
  logic tmr_req = 1'b0;
  logic pin;
  logic tmr;
  logic [7:0] o_rdata;
  logic o_conv_busy_flag;
  logic o_conv_end_irq;
  logic [15:0] o_result;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  int n;
  int s;
  int cv;

  adcm_top adcm_top_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_bit_access(i_bit_access), .i_bit_idx(i_bit_idx), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_other_ctl_wr(i_other_ctl_wr), .i_ext_trigger_pin(pin), .i_timer_trig(tmr),
    .i_timer_src_sel(i_timer_src_sel), .i_sar_result(i_sar_result), .o_conv_busy_flag(o_conv_busy_flag),
    .o_conv_end_irq(o_conv_end_irq), .o_result(o_result));
  adcm_trig_model adcm_trig_model_i (.i_core_clk(i_core_clk), .i_pin_req(pin_req), .i_timer_req(tmr_req),
    .o_pin(pin), .o_timer(tmr));

  always #5 i_core_clk = ~i_core_clk;

  // ==========================================================
  // tasks
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // a hang costs one mismatch; whole run needs about 7700 cycles
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_n(input string nm, input int e, input int g);
    n_checks++;
    if (g != e) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_n

  // bus tasks end one idle cycle after the access, so back-to-back calls never retoggle a strobe in one step
  task automatic wr(input logic [27:0] a, input logic [7:0] d, input logic b = 1'b0, input logic [2:0] ix = 3'h0);
    i_addr = a;
    i_wdata = d;
    i_bit_access = b;
    i_bit_idx = ix;
    i_wr_en = 1'b1;
    @(negedge i_core_clk);
    i_wr_en = 1'b0;
    @(negedge i_core_clk);
  endtask : wr

  task automatic rdc(input logic [27:0] a, input logic [7:0] e, input string nm, input logic b = 1'b0,
                     input logic [2:0] ix = 3'h0);
    i_addr = a;
    i_bit_access = b;
    i_bit_idx = ix;
    i_rd_en = 1'b1;
    @(negedge i_core_clk);
    i_rd_en = 1'b0;
    chk(nm, {8'h00, e}, {8'h00, o_rdata});
    @(negedge i_core_clk);
  endtask : rdc

  // falling edges until the end event, the one at the call counting as 1
  task automatic meas(output int c);
    c = 1;
    while (o_conv_end_irq !== 1'b1 && c < 1000) begin
      @(negedge i_core_clk);
      c++;
    end
  endtask : meas

  task automatic count_irq(input int len, output int c);
    c = 0;
    repeat (len) begin
      if (o_conv_end_irq === 1'b1) c++;
      @(negedge i_core_clk);
    end
  endtask : count_irq

  task automatic pulse_other();
    i_other_ctl_wr = 1'b1;
    @(negedge i_core_clk);
    i_other_ctl_wr = 1'b0;
  endtask : pulse_other

  task automatic fire_timer();
    tmr_req = 1'b1;
    @(negedge i_core_clk);
    tmr_req = 1'b0;
    @(negedge i_core_clk);
  endtask : fire_timer

  // ==========================================================
  // test sequence
  initial begin
    repeat (4) @(negedge i_core_clk);
    i_rst = 1'b0;
    rdc(ADCM_ADDR_MODE0, 8'h00, "mode0 reset");
    rdc(ADCM_ADDR_MODE1, 8'h00, "mode1 reset");
    wr(ADCM_ADDR_MODE0, 8'h7f);
    rdc(ADCM_ADDR_MODE0, 8'h3e, "mode0 fields");
    wr(ADCM_ADDR_MODE1, 8'hff);
    rdc(ADCM_ADDR_MODE1, 8'h87, "mode1 fields");
    wr(ADCM_ADDR_MODE1, 8'h00, 1'b1, 3'h7);
    rdc(ADCM_ADDR_MODE1, 8'h07, "bit clear");
    rdc(ADCM_ADDR_MODE1, 8'h01, "bit read", 1'b1, 3'h2);
    wr(28'hffff210, 8'hff);
    rdc(28'hffff210, 8'h00, "unmapped");
    // continuous modes repeat, one-shot modes stop after one end event
    wr(ADCM_ADDR_MODE1, 8'h80);
    for (int op = 0; op < 4; op++) begin
      wr(ADCM_ADDR_MODE0, 8'h00);
      wr(ADCM_ADDR_MODE0, {2'b10, op[1:0], 4'h0});
      count_irq(100, n);
      chk_n("op mode events", op[1] ? 1 : 3, n);
      chk("one-shot busy", {15'h0, ~op[1]}, {15'h0, o_conv_busy_flag});
    end
    // stabilization, conversion and wait counts for every code and both speeds
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 8; c++) begin
        s = (c < 3) ? 13 * (c + 1) : 50;
        cv = (c < 3) ? 26 * (c + 1) : 104 + 26 * (c - 3);
        wr(ADCM_ADDR_MODE0, 8'h00);
        wr(ADCM_ADDR_MODE1, {h[0], 4'h0, c[2:0]});
        i_sar_result = 10'h2a5 ^ c[9:0];
        wr(ADCM_ADDR_MODE0, 8'h80);
        chk("busy", 16'h1, {15'h0, o_conv_busy_flag});
        meas(k);
        // wr returns one idle cycle after its accepting edge
        chk_n("latency", h ? s + cv : s + 2 * cv, k);
        chk("result", {i_sar_result, 6'h00}, o_result);
        if (h == 1) begin
          @(negedge i_core_clk);
          meas(k);
          chk_n("period", cv, k);
        end
      end
    end
    wr(ADCM_ADDR_MODE0, 8'h00);
    chk("stopped busy", 16'h0, {15'h0, o_conv_busy_flag});
    count_irq(60, n);
    chk_n("stopped events", 0, n);
    // software trigger: a control write mid-conversion restarts from stabilization
    wr(ADCM_ADDR_MODE1, 8'h80);
    wr(ADCM_ADDR_MODE0, 8'h80);
    rdc(ADCM_ADDR_MODE0, 8'h81, "busy read");
    repeat (18) @(negedge i_core_clk);
    pulse_other();
    meas(k);
    chk_n("restart latency", 40, k);
    // timer trigger: response delay plus conversion, high speed only
    i_timer_src_sel = 1'b1;
    for (int c = 0; c < 8; c++) begin
      cv = (c < 3) ? 26 * (c + 1) : 104 + 26 * (c - 3);
      wr(ADCM_ADDR_MODE0, 8'h00);
      wr(ADCM_ADDR_MODE1, {5'h10, c[2:0]});
      wr(ADCM_ADDR_MODE0, 8'h82);
      repeat (60) @(negedge i_core_clk);
      fire_timer();
      meas(k);
      chk_n("trigger latency", 1 + 4 + c + cv, k);
    end
    // control write during the trigger response delay aborts and waits for the next trigger
    fire_timer();
    repeat (10) @(negedge i_core_clk);
    pulse_other();
    count_irq(250, n);
    chk_n("aborted events", 0, n);
    fire_timer();
    meas(k);
    chk_n("after abort", 1 + 11 + 208, k);
    // pin edge selection: one rising then one falling edge per code
    i_timer_src_sel = 1'b0;
    wr(ADCM_ADDR_MODE1, 8'h80);
    for (int e = 0; e < 4; e++) begin
      wr(ADCM_ADDR_MODE0, 8'h00);
      wr(ADCM_ADDR_MODE0, {4'h8, e[1:0], 2'b10});
      repeat (20) @(negedge i_core_clk);
      s = 0;
      repeat (2) begin
        pin_req = 1'b1;
        @(negedge i_core_clk);
        pin_req = 1'b0;
        count_irq(60, n);
        s += n;
      end
      chk_n("edge events", (e == 3) ? 2 : ((e == 0) ? 0 : 1), s);
    end
    wr(ADCM_ADDR_MODE0, 8'h00);
    report_and_stop();
  end
endmodule : tb_top
